// ===== voice_record_pause_control_tb.sv
// self-checking bench for the voice record sequencer
`timescale 1ns/10ps
module voice_record_pause_control_tb;
  localparam int STM_C = 20;
  localparam int PDB = 20;
  localparam int DLA = 20;
  localparam int DL1 = 20;
  logic clock;
  logic rst;
  logic sel;
  logic [2:0] pin_n; // start, stop, pause; active low
  logic voice;
  logic eod;
  logic rec;
  logic cont;
  logic pd_n;
  logic cmd_write;
  logic [3:0] cmd_nibble;
  logic activity_monitor_output;
  logic osc_running;
  logic voice_activation_enabled;
  logic [7:0] output_level;
  vrp_pkg::vrp_status_s status;
  int bad_count;
  int samples_checked;
  int n;
  vrp_seq #(.RST_BUSY(20), .PD_BUSY(PDB), .STM(STM_C), .DEL_ALL(DLA),
    .DEL_ONE(DL1)) vrp_seq_i (.clock(clock), .rst(rst),
    .voice_activation_select(sel), .start_pulse_input(pin_n[0]),
    .stop_pulse_input(pin_n[1]), .pause_pulse_input(pin_n[2]),
    .voice_detected(voice), .end_of_data(eod), .record_mode(rec),
    .continuous_play(cont), .power_down_input(pd_n),
    .cmd_write(cmd_write), .cmd_nibble(cmd_nibble),
    .activity_monitor_output(activity_monitor_output),
    .osc_running(osc_running),
    .voice_activation_enabled(voice_activation_enabled),
    .output_level(output_level), .status(status));
  vrp_host vrp_host_i (.clock(clock), .busy(status.busy),
    .cmd_write(cmd_write), .cmd_nibble(cmd_nibble));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // waits for an output to reach val within lim cycles
  task automatic wait_on(input int s, input logic val, input int lim);
    logic v;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      case (s)
        0: v = status.busy;
        1: v = activity_monitor_output;
        2: v = status.pause_or_voice_wait_flag;
        default: v = osc_running;
      endcase
    end while (v !== val && n < lim);
    chk(v, val);
  endtask
  // low pulse of four cycles on one pin
  task automatic pin(input int which);
    @(posedge clock);
    pin_n[which] <= 1'b0;
    repeat (4) @(posedge clock);
    pin_n[which] <= 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (300000) @(posedge clock);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    sel = 1'b0;
    pin_n = 3'h7;
    voice = 1'b0;
    eod = 1'b0;
    rec = 1'b0;
    cont = 1'b0;
    pd_n = 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wait_on(0, 1'b0, 3);
    chk(activity_monitor_output, 1'b0);
    chk(output_level, 8'h00);
    chk(status.next_phrase_accept_flag, 1'b1);
    for (int i = 1; i >= 0; i--) begin
      @(posedge clock);
      sel <= i[0];
      repeat (2) @(posedge clock);
      chk(voice_activation_enabled, i[0]);
    end
    // playback by command, then address write with one data nibble
    vrp_host_i.send(4'h1, 0);
    wait_on(0, 1'b1, 3);
    wait_on(1, 1'b1, STM_C + 4);
    wait_on(0, 1'b0, vrp_pkg::C_CMD + 4);
    vrp_host_i.send(4'h2, 0);
    wait_on(1, 1'b0, vrp_pkg::C_CMD + 4);
    vrp_host_i.send(4'h5, 0);
    wait_on(0, 1'b1, 3);
    wait_on(0, 1'b0, vrp_pkg::C_ADRCMD + 4);
    vrp_host_i.send(4'hc, 0);
    wait_on(0, 1'b1, 3);
    wait_on(0, 1'b0, vrp_pkg::C_ADRNIB + 4);
    vrp_host_i.send(4'h4, vrp_pkg::C_ADRCMD);
    vrp_host_i.send(4'h6, vrp_pkg::C_ADRCMD);
    vrp_host_i.send(4'h7, DLA);
    vrp_host_i.send(4'h8, DL1);
    wait_on(0, 1'b0, vrp_pkg::C_CMD + 4);
    // voice activated record, pause, resume, stop
    rec <= 1'b1;
    sel <= 1'b1;
    pin(0);
    wait_on(2, 1'b1, 4);
    repeat (30) @(posedge clock);
    chk(activity_monitor_output, 1'b0);
    voice <= 1'b1;
    wait_on(1, 1'b1, STM_C + 4);
    voice <= 1'b0;
    repeat (40) @(posedge clock);
    chk(activity_monitor_output, 1'b1);
    pin(2);
    wait_on(2, 1'b1, vrp_pkg::C_CMD);
    pin(0);
    wait_on(1, 1'b1, STM_C + 8);
    wait_on(2, 1'b0, 62504);
    pin(1);
    wait_on(1, 1'b0, vrp_pkg::C_CMD + 4);
    // stop while waiting for voice
    pin(0);
    wait_on(2, 1'b1, 4);
    pin(1);
    wait_on(2, 1'b0, 4);
    chk(activity_monitor_output, 1'b0);
    // continuous playback: accept flag and gap after a phrase
    cont <= 1'b1;
    rec <= 1'b0;
    pin(0);
    chk(status.next_phrase_accept_flag, 1'b0);
    wait_on(1, 1'b1, STM_C + 4);
    chk(status.record_play_active_flag, 1'b1);
    eod <= 1'b1;
    @(posedge clock);
    eod <= 1'b0;
    wait_on(1, 1'b0, 4);
    chk(status.next_phrase_accept_flag, 1'b1);
    pin(1);
    chk(status.record_play_active_flag, 1'b0);
    cont <= 1'b0;
    // power-down hold and busy after release
    pd_n <= 1'b0;
    wait_on(3, 1'b0, 62504);
    chk(n >= vrp_pkg::C_PDOSC - 2, 1'b1);
    pd_n <= 1'b1;
    wait_on(0, 1'b1, 3);
    wait_on(0, 1'b0, PDB + 6);
    tally_and_finish();
  end
endmodule
bind vrp_seq vrp_seq_asserts #(.STM(STM), .PD_BUSY(PD_BUSY),
  .DEL_ALL(DEL_ALL), .DEL_ONE(DEL_ONE)) vrp_seq_asserts_i (
  .clock(clock), .rst(rst),
  .voice_activation_select(voice_activation_select),
  .start_pulse_input(start_pulse_input),
  .stop_pulse_input(stop_pulse_input),
  .pause_pulse_input(pause_pulse_input),
  .voice_detected(voice_detected), .end_of_data(end_of_data),
  .record_mode(record_mode), .power_down_input(power_down_input),
  .cmd_write(cmd_write), .cmd_nibble(cmd_nibble),
  .activity_monitor_output(activity_monitor_output),
  .osc_running(osc_running),
  .voice_activation_enabled(voice_activation_enabled), .status(status));

// ===== vrp_host.sv
// host model that writes command nibbles and honours busy
`timescale 1ns/10ps
module vrp_host (
  input wire logic clock,
  input wire logic busy,
  output logic cmd_write,
  output logic [3:0] cmd_nibble
);
  initial begin
    cmd_write = 1'b0;
    cmd_nibble = 4'h0;
  end
  task automatic send(input logic [3:0] nib, input int gap);
    int n;
    n = 0;
    @(posedge clock);
    while (busy !== 1'b0 && n < 100000) begin
      @(posedge clock);
      n++;
    end
    cmd_write <= 1'b1;
    cmd_nibble <= nib;
    @(posedge clock);
    cmd_write <= 1'b0;
    cmd_nibble <= ~nib; // released bus shows no stale value
    repeat (gap) @(posedge clock);
  endtask
endmodule

// ===== vrp_level.sv
// output dc level ramp: rise and fall at their own step rates
`timescale 1ns/10ps
module vrp_level (
  input wire logic clock,
  input wire logic rst,
  input wire logic up,
  input wire logic down,
  input wire logic hold,
  output logic [7:0] level,
  output logic moving
);

  localparam logic [7:0] TOP = 8'hff;
  localparam int SR = vrp_pkg::C_LVR / 255;
  localparam int SF = vrp_pkg::C_LVF / 255;
  logic [vrp_pkg::TW-1:0] div_q;
  logic dir_q;
  logic step;

  // step enable divider; rise 64 ms, fall 256 ms over full span
  assign step = (div_q == vrp_pkg::TZERO);
  always_ff @(posedge clock) begin
    if (rst || up || down || step) begin
      div_q <= (up || (dir_q && !down)) ? vrp_pkg::TW'(SR) :
               vrp_pkg::TW'(SF);
    end else if (!hold) begin
      div_q <= div_q - vrp_pkg::TONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      level <= 8'h00;
      dir_q <= 1'b0;
    end else if (up || down) begin
      dir_q <= up;
    end else if (step && !hold) begin
      if (dir_q && level != TOP) level <= level + 8'h01;
      else if (!dir_q && level != 8'h00) level <= level - 8'h01;
    end
  end

  assign moving = dir_q ? (level != TOP) : (level != 8'h00);

endmodule

// ===== vrp_pkg.sv
// package of constants, states and carriers for the voice record sequencer
package vrp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int T_CMD_US = 16;
  localparam int T_ADRCMD_US = 270;
  localparam int T_ADRNIB_US = 50;
  localparam int T_RST_MS = 1;
  localparam int T_PDOSC_US = 125;
  localparam int T_PDBUSY_US = 250;
  localparam int T_MID_US = 1250;
  localparam int T_MONH_US = 31;
  localparam int T_MONL_US = 94;
  localparam int T_EXTM_US = 330;
  localparam int T_LVR_MS = 64;
  localparam int T_LVF_MS = 256;
  localparam int T_DELA_MS = 550;
  localparam int T_DEL1_MS = 70;
  localparam int T_STM_US = 1000;

  // counts scale with the clock rate
  // counts: least times round up, longest round down
  localparam int C_CMD = T_CMD_US * CLK_KHZ / 1000;
  localparam int C_ADRCMD = T_ADRCMD_US * CLK_KHZ / 1000;
  localparam int C_ADRNIB = T_ADRNIB_US * CLK_KHZ / 1000;
  localparam int C_RST = T_RST_MS * CLK_KHZ;
  localparam int C_PDOSC = (T_PDOSC_US * CLK_KHZ + 999) / 1000;
  localparam int C_PDBUSY = (T_PDBUSY_US * CLK_KHZ + 999) / 1000;
  localparam int C_MID = T_MID_US * CLK_KHZ / 1000;
  localparam int C_MONH = T_MONH_US * CLK_KHZ / 1000;
  localparam int C_MONL = T_MONL_US * CLK_KHZ / 1000;
  localparam int C_EXTM = T_EXTM_US * CLK_KHZ / 1000;
  localparam int C_LVR = T_LVR_MS * CLK_KHZ;
  localparam int C_LVF = T_LVF_MS * CLK_KHZ;
  localparam int C_DELA = T_DELA_MS * CLK_KHZ;
  localparam int C_DEL1 = T_DEL1_MS * CLK_KHZ;
  localparam int C_STM = T_STM_US * CLK_KHZ / 1000;

  localparam int TW = 28;
  localparam logic [TW-1:0] TZERO = 28'h000_0000;
  localparam logic [TW-1:0] TONE = 28'h000_0001;

  // ----------------------------------------------------------------
  // commands (nibble codes, our own numbering)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    VRP_NOP = 4'h0, VRP_START = 4'h1, VRP_STOP = 4'h2, VRP_PAUSE = 4'h3,
    VRP_BLOCK_COUNT_READ_CMD = 4'h4, VRP_ADDRESS_WRITE_CMD = 4'h5, VRP_ADDRESS_READ_CMD = 4'h6,
    VRP_DELA = 4'h7, VRP_DEL1 = 4'h8, VRP_LEVUP = 4'h9,
    VRP_LEVDN = 4'ha, VRP_EXTC = 4'hb, VRP_DATA = 4'hc
  } vrp_cmd_e;

  // sequencer states, gray along idle-wait-active-pause
  typedef enum logic [2:0] {
    VRP_IDLE = 3'b000, VRP_WAIT = 3'b001, VRP_ACT = 3'b011,
    VRP_PAUS = 3'b010, VRP_EXT = 3'b110
  } vrp_state_e;

  // status carried out together
  typedef struct packed {
    logic busy;
    logic record_play_active_flag;
    logic pause_or_voice_wait_flag;
    logic next_phrase_accept_flag;
  } vrp_status_s;

endpackage

// ===== vrp_seq.sv
// record, play and pause sequencer with host command busy timing
`timescale 1ns/10ps
module vrp_seq #(
  parameter int RST_BUSY = vrp_pkg::C_RST,
  parameter int PD_BUSY = vrp_pkg::C_PDBUSY,
  parameter int STM = vrp_pkg::C_STM,
  parameter int LV_UNUSED = vrp_pkg::C_LVR,
  parameter int DEL_ALL = vrp_pkg::C_DELA,
  parameter int DEL_ONE = vrp_pkg::C_DEL1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic voice_activation_select,
  input wire logic start_pulse_input,
  input wire logic stop_pulse_input,
  input wire logic pause_pulse_input,
  input wire logic voice_detected,
  input wire logic end_of_data,
  input wire logic record_mode,
  input wire logic continuous_play,
  input wire logic power_down_input,
  input wire logic cmd_write,
  input wire logic [3:0] cmd_nibble,
  output logic activity_monitor_output,
  output logic osc_running,
  output logic voice_activation_enabled,
  output logic [7:0] output_level,
  output vrp_pkg::vrp_status_s status
);

  vrp_pkg::vrp_state_e st_q;
  logic st_prev_q, sp_prev_q, pa_prev_q, pd_prev_q;
  logic start_ev, stop_ev, pause_ev;
  logic was_rec_q, gap_q, busy_q, nar_q;
  logic [3:0] nib_q;
  logic pd_q;
  logic tb_load, tb_run, tb_done;
  logic [vrp_pkg::TW-1:0] tb_cnt;
  logic tm_load, tm_run, tm_done;
  logic [vrp_pkg::TW-1:0] tm_cnt;
  logic po_load, po_run;
  logic lv_up, lv_dn, lv_mov;
  vrp_pkg::vrp_cmd_e cmd;

  // ----------------------------------------------------------------
  // input events
  // ----------------------------------------------------------------

  // falling edges of the low-active pins, or the matching command
  always_ff @(posedge clock) begin
    if (rst) begin
      st_prev_q <= 1'b1;
      sp_prev_q <= 1'b1;
      pa_prev_q <= 1'b1;
      pd_prev_q <= 1'b1;
    end else begin
      st_prev_q <= start_pulse_input;
      sp_prev_q <= stop_pulse_input;
      pa_prev_q <= pause_pulse_input;
      pd_prev_q <= power_down_input;
    end
  end

  assign cmd = vrp_pkg::vrp_cmd_e'(cmd_nibble);
  assign start_ev = (st_prev_q && !start_pulse_input) ||
                    (cmd_write && cmd == vrp_pkg::VRP_START);
  assign stop_ev = (sp_prev_q && !stop_pulse_input) ||
                   (cmd_write && cmd == vrp_pkg::VRP_STOP);
  assign pause_ev = (pa_prev_q && !pause_pulse_input) ||
                    (cmd_write && cmd == vrp_pkg::VRP_PAUSE);

  assign voice_activation_enabled = voice_activation_select;

  // ----------------------------------------------------------------
  // busy timer
  // ----------------------------------------------------------------

  // busy duration per command, each at or under its maximum except nibble f, which keeps busy set until reset
  always_comb begin
    tb_load = 1'b0;
    tb_cnt = vrp_pkg::TW'(vrp_pkg::C_CMD);
    if (pd_prev_q && !power_down_input) begin
      tb_load = 1'b0;
    end else if (!pd_prev_q && power_down_input) begin
      tb_load = 1'b1;
      tb_cnt = vrp_pkg::TW'(PD_BUSY);
    end else if (cmd_write && !busy_q) begin
      tb_load = 1'b1;
      unique case (cmd)
        vrp_pkg::VRP_ADDRESS_WRITE_CMD: tb_cnt = vrp_pkg::TW'(vrp_pkg::C_ADRCMD);
        vrp_pkg::VRP_DATA: tb_cnt = (nib_q == vrp_pkg::VRP_ADDRESS_WRITE_CMD) ?
          vrp_pkg::TW'(vrp_pkg::C_ADRNIB) : vrp_pkg::TW'(vrp_pkg::C_CMD);
        vrp_pkg::VRP_DELA: tb_cnt = vrp_pkg::TW'(DEL_ALL);
        vrp_pkg::VRP_DEL1: tb_cnt = vrp_pkg::TW'(DEL_ONE);
        default: tb_cnt = vrp_pkg::TW'(vrp_pkg::C_CMD);
      endcase
    end
  end

  vrp_timer u_busy (
    .clock(clock),
    .rst(rst),
    .load(tb_load),
    .count(tb_cnt),
    .running(tb_run),
    .done()
  );

  // busy set in reset, cleared on the first clock after reset release
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_q <= 1'b1;
      nib_q <= 4'h0;
    end else begin
      busy_q <= tb_run || tb_load || (busy_q && !tb_run && nib_q == 4'hf);
      if (cmd_write && !busy_q && cmd != vrp_pkg::VRP_DATA) begin
        nib_q <= cmd_nibble;
      end
    end
  end

  // ----------------------------------------------------------------
  // power down and oscillator
  // ----------------------------------------------------------------

  // oscillator runs a hold time after power-down falls
  assign po_load = pd_prev_q && !power_down_input;
  vrp_timer u_osc (
    .clock(clock),
    .rst(rst),
    .load(po_load),
    .count(vrp_pkg::TW'(vrp_pkg::C_PDOSC)),
    .running(po_run),
    .done()
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= !power_down_input && !po_load && !po_run;
    end
  end
  assign osc_running = !pd_q;

  // ----------------------------------------------------------------
  // monitor and gap timer
  // ----------------------------------------------------------------

  // start delay before monitor rise; transfer pulse cadence
  always_comb begin
    tm_load = 1'b0;
    tm_cnt = vrp_pkg::TW'(STM);
    if (st_q == vrp_pkg::VRP_IDLE && start_ev) begin
      tm_load = 1'b1;
    end else if (cmd_write && !busy_q && cmd == vrp_pkg::VRP_EXTC) begin
      tm_load = 1'b1;
      tm_cnt = vrp_pkg::TW'(vrp_pkg::C_EXTM);
    end else if (st_q == vrp_pkg::VRP_EXT && tm_done) begin
      tm_load = 1'b1;
      tm_cnt = activity_monitor_output ? vrp_pkg::TW'(vrp_pkg::C_MONL) :
               vrp_pkg::TW'(vrp_pkg::C_MONH);
    end else if (st_q == vrp_pkg::VRP_ACT && end_of_data &&
                 continuous_play && !record_mode) begin
      tm_load = 1'b1;
      tm_cnt = vrp_pkg::TW'(vrp_pkg::C_MID);
    end
  end

  vrp_timer u_mon (
    .clock(clock),
    .rst(rst),
    .load(tm_load),
    .count(tm_cnt),
    .running(tm_run),
    .done(tm_done)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= vrp_pkg::VRP_IDLE;
      was_rec_q <= 1'b0;
      gap_q <= 1'b0;
    end else if (!pd_q) begin
      unique case (st_q)
        vrp_pkg::VRP_IDLE: begin
          was_rec_q <= record_mode;
          if (cmd_write && !busy_q && cmd == vrp_pkg::VRP_EXTC) begin
            st_q <= vrp_pkg::VRP_EXT;
          end else if (start_ev) begin
            // wait for voice when recording with activation on
            if (record_mode && voice_activation_select) begin
              st_q <= vrp_pkg::VRP_WAIT;
            end else begin
              st_q <= vrp_pkg::VRP_ACT;
            end
          end
        end
        vrp_pkg::VRP_WAIT: begin
          // stop returns to standby; left at once
          if (stop_ev) begin
            st_q <= vrp_pkg::VRP_IDLE;
          end else if (voice_detected) begin
            st_q <= vrp_pkg::VRP_ACT;
          end
        end
        vrp_pkg::VRP_ACT: begin
          // silence after first detection is ignored here
          if (stop_ev) begin
            st_q <= vrp_pkg::VRP_IDLE;
          end else if (pause_ev) begin
            st_q <= vrp_pkg::VRP_PAUS;
          end else if (end_of_data) begin
            gap_q <= continuous_play && !record_mode;
            if (!(continuous_play && !record_mode)) begin
              st_q <= vrp_pkg::VRP_IDLE;
            end
          end else if (gap_q && !tm_run) begin
            gap_q <= 1'b0;
          end
        end
        vrp_pkg::VRP_PAUS: begin
          // stop ends, start resumes; no voice wait on resume
          if (stop_ev) begin
            st_q <= vrp_pkg::VRP_IDLE;
          end else if (start_ev) begin
            st_q <= vrp_pkg::VRP_ACT;
          end
        end
        vrp_pkg::VRP_EXT: begin
          if (stop_ev) begin
            st_q <= vrp_pkg::VRP_IDLE;
          end
        end
        default: st_q <= vrp_pkg::VRP_IDLE;
      endcase
    end
  end

  // monitor high in active state once start delay done and outside a phrase gap
  always_ff @(posedge clock) begin
    if (rst) begin
      activity_monitor_output <= 1'b0;
    end else if (st_q == vrp_pkg::VRP_EXT) begin
      // toggles high/low on each timer expiry
      if (tm_done) activity_monitor_output <= !activity_monitor_output;
    end else begin
      activity_monitor_output <= (st_q == vrp_pkg::VRP_ACT) && !tm_run &&
                                 !gap_q;
    end
  end

  // accept flag drops on start during continuous play
  always_ff @(posedge clock) begin
    if (rst) begin
      nar_q <= 1'b1;
    end else if (start_ev && continuous_play) begin
      nar_q <= 1'b0;
    end else if (st_q == vrp_pkg::VRP_IDLE || gap_q) begin
      nar_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // level ramp and status
  // ----------------------------------------------------------------

  assign lv_up = cmd_write && !busy_q && cmd == vrp_pkg::VRP_LEVUP;
  assign lv_dn = cmd_write && !busy_q && cmd == vrp_pkg::VRP_LEVDN;

  vrp_level u_level (
    .clock(clock),
    .rst(rst),
    .up(lv_up),
    .down(lv_dn),
    .hold(pd_q),
    .level(output_level),
    .moving(lv_mov)
  );

  // busy on status; pause flag
  assign status.busy = busy_q;
  assign status.record_play_active_flag = (st_q == vrp_pkg::VRP_ACT) ||
                                          (st_q == vrp_pkg::VRP_EXT);
  assign status.pause_or_voice_wait_flag = (st_q == vrp_pkg::VRP_PAUS) ||
                                           (st_q == vrp_pkg::VRP_WAIT);
  assign status.next_phrase_accept_flag = nar_q;

endmodule

// ===== vrp_seq_asserts.sv
// concurrent checks on the ports of the voice record sequencer
`timescale 1ns/10ps
module vrp_seq_asserts #(
  parameter int STM = 20,
  parameter int PD_BUSY = 20,
  parameter int DEL_ALL = 20,
  parameter int DEL_ONE = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic voice_activation_select,
  input wire logic start_pulse_input,
  input wire logic stop_pulse_input,
  input wire logic pause_pulse_input,
  input wire logic voice_detected,
  input wire logic end_of_data,
  input wire logic record_mode,
  input wire logic power_down_input,
  input wire logic cmd_write,
  input wire logic [3:0] cmd_nibble,
  input wire logic activity_monitor_output,
  input wire logic osc_running,
  input wire logic voice_activation_enabled,
  input wire vrp_pkg::vrp_status_s status
);
  localparam int MON_LIM = STM + 4;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic take;
  logic armed_q;
  logic adr_q;
  logic [19:0] age_q;
  logic [19:0] lim_q;
  logic [19:0] pd_q;
  assign take = cmd_write && !status.busy;
  // age of the busy period that an accepted command opened
  always_ff @(posedge clock) begin
    if (rst || take) begin
      age_q <= 20'h0_0000;
    end else begin
      age_q <= age_q + 20'h0_0001;
    end
  end
  // longest busy period allowed for the accepted command
  always_ff @(posedge clock) begin
    if (rst) begin
      armed_q <= 1'b0;
      adr_q <= 1'b0;
      lim_q <= 20'h0_0000;
    end else if (take) begin
      armed_q <= 1'b1;
      adr_q <= (cmd_nibble == 4'h5) || (adr_q && cmd_nibble == 4'hc);
      case (cmd_nibble)
        4'h5: lim_q <= 20'(vrp_pkg::C_ADRCMD);
        4'h7: lim_q <= 20'(DEL_ALL);
        4'h8: lim_q <= 20'(DEL_ONE);
        4'hc: lim_q <= adr_q ? 20'(vrp_pkg::C_ADRNIB) : 20'(vrp_pkg::C_CMD);
        default: lim_q <= 20'(vrp_pkg::C_CMD);
      endcase
    end else if (!status.busy) begin
      armed_q <= 1'b0;
    end
  end
  // cycles spent with power-down held low
  always_ff @(posedge clock) begin
    if (rst || power_down_input) begin
      pd_q <= 20'h0_0000;
    end else if (pd_q != 20'hf_ffff) begin
      pd_q <= pd_q + 20'h0_0001;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_sel_follow: assert property (
    voice_activation_enabled == voice_activation_select)
    else $error("activation enable differs from select");
  a_busy_rises: assert property (
    take |=> status.busy) else $error("busy missing after command");
  a_busy_bound: assert property (
    armed_q && status.busy |-> age_q <= lim_q + 20'h0_0002)
    else $error("busy lasted too long");
  a_wait_enter: assert property (
    $fell(start_pulse_input) && voice_activation_select && record_mode &&
    !activity_monitor_output && !status.pause_or_voice_wait_flag &&
    !status.busy |-> ##[1:3] (status.pause_or_voice_wait_flag &&
    !activity_monitor_output)) else $error("no voice wait on start");
  a_voice_start: assert property (
    status.pause_or_voice_wait_flag && !activity_monitor_output &&
    voice_detected && record_mode && stop_pulse_input |->
    ##[1:MON_LIM] activity_monitor_output)
    else $error("voice did not start recording");
  a_stop_wait: assert property (
    status.pause_or_voice_wait_flag && !activity_monitor_output &&
    $fell(stop_pulse_input) |-> ##[1:MON_LIM]
    !status.pause_or_voice_wait_flag) else $error("stop left wait late");
  a_rec_hold: assert property (
    activity_monitor_output && record_mode && stop_pulse_input &&
    pause_pulse_input && !end_of_data && !cmd_write && power_down_input
    |=> activity_monitor_output) else $error("recording dropped");
  a_pause_set: assert property (
    activity_monitor_output && $fell(pause_pulse_input) |->
    ##[1:1000] status.pause_or_voice_wait_flag)
    else $error("pause flag not set");
  a_osc_hold: assert property (
    !power_down_input && pd_q < 20'(vrp_pkg::C_PDOSC - 2) |-> osc_running)
    else $error("oscillator halted early");
  a_osc_stop: assert property (
    pd_q > 20'h0_f424 |-> !osc_running) else $error("oscillator still on");
  a_pd_busy: assert property (
    $rose(power_down_input) |-> ##[0:2] status.busy)
    else $error("no busy after power-down release");
endmodule

// ===== vrp_timer.sv
// down-counting timer that signals expiry with a one-cycle pulse
`timescale 1ns/10ps
module vrp_timer (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [vrp_pkg::TW-1:0] count,
  output logic running,
  output logic done
);

  logic [vrp_pkg::TW-1:0] cnt_q;

  // load and count down to zero
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= vrp_pkg::TZERO;
      done <= 1'b0;
    end else begin
      done <= (cnt_q == vrp_pkg::TONE) && !load;
      if (load) begin
        cnt_q <= count;
      end else if (cnt_q != vrp_pkg::TZERO) begin
        cnt_q <= cnt_q - vrp_pkg::TONE;
      end
    end
  end

  assign running = (cnt_q != vrp_pkg::TZERO);

endmodule
